// file: output_trigger_and_pin_filter_regs.svh
// Notes on behaviour
// - Start trigger on selectable rising or falling edge
// - Start source: software, terminal, input triggers, internal
// - Routed start trigger is an active-high pulse
// - Active pause blocks every sample update
// - Pause never cuts a running sample update
// - Onboard clock resumes at once on unpause
// - Other clocks resume on next edge after unpause
// - Pause polarity is selectable, high or low
// - Pause source: terminal or internal signal
// - Each terminal has its own enabled filter
// - Level passes after N matching filter samples
// - Short, medium, high presets plus custom width
// - Presets sample fast or slow; custom clock
// - Filtering adds one filter clock period jitter
// - All terminal filters disabled after reset
// - Software start; delay option with onboard clock
// - Sample clock output is active high
`ifndef OUTPUT_TRIGGER_AND_PIN_FILTER_REGS_SVH
`define OUTPUT_TRIGGER_AND_PIN_FILTER_REGS_SVH

// Register byte offsets
`define OFS_CTRL       5'h00
`define OFS_CMD        5'h04
`define OFS_FLT_EN     5'h08
`define OFS_FLT_SET    5'h0C
`define OFS_CUSTOM     5'h10
`define OFS_TIMING     5'h14
`define OFS_PFT_LEVEL  5'h18

// Control fields
`define CTRL_TRIG_EN    0
`define CTRL_EDGE_FALL  1
`define CTRL_START_SRC  4
`define CTRL_PAUSE_EN   8
`define CTRL_PAUSE_HIGH 9
`define CTRL_PAUSE_SRC  12
`define CTRL_ONBOARD    16
`define CTRL_EXT_SRC    20
`define SRC_W           4

// Command and status bits
`define CMD_GO      0
`define CMD_SWTRIG  1
`define CMD_STOP    2
`define STAT_ARMED  0
`define STAT_RUN    1
`define STAT_PAUSED 2

// Reset values
`define CTRL_RST    32'h0001_0000
`define CUSTOM_RST  32'h0001_0001
`define TIMING_RST  32'h0000_0014
`define FLT_EN_RST  32'h0000_0000

// Timing figures, and sample counts derived from the system clock
`define CLK_PERIOD_PS   50000
`define CLK_PERIOD_NS   50
`define FLT_FAST_CLK_PS 12500
`define FLT_SLOW_CLK_NS 10000
`define FLT_SHORT_PS    112500
`define FLT_MED_PS      6400000
`define FLT_HIGH_NS     2560000
`define FLT_FAST_DIV    ((`FLT_FAST_CLK_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FLT_FAST_PS     (`FLT_FAST_DIV * `CLK_PERIOD_PS)
`define FLT_SHORT_N     ((`FLT_SHORT_PS + `FLT_FAST_PS - 1) / `FLT_FAST_PS)
`define FLT_MED_N       ((`FLT_MED_PS + `FLT_FAST_PS - 1) / `FLT_FAST_PS)
`define FLT_SLOW_DIV    (`FLT_SLOW_CLK_NS / `CLK_PERIOD_NS)
`define FLT_HIGH_N      ((`FLT_HIGH_NS + `FLT_SLOW_CLK_NS - 1) / `FLT_SLOW_CLK_NS)
`define SAMPLE_HIGH     2

`endif

// file: output_trigger_pkg.sv
package output_trigger_pkg;

	// Generation sequencing
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_RUN} genState_t;

	// Per-terminal filter settings
	typedef enum logic [1:0] {FLT_SHORT, FLT_MED, FLT_HIGH, FLT_CUSTOM} fltSet_t;

endpackage

// file: output_trigger_and_pin_filter.sv
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "output_trigger_and_pin_filter_regs.svh"

module output_trigger_and_pin_filter #(
	parameter int NPFT = 4,
	parameter int NINT = 2
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	// Avalon-MM slave
	input  wire logic [4:0]      address,
	input  wire logic            read,
	input  wire logic            write,
	input  wire logic [31:0]     writedata,
	output logic      [31:0]     readdata,
	output logic                 waitrequest,
	// Trigger and clock sources
	input  wire logic [NPFT-1:0] pftIn,
	input  wire logic            inputRefTrig,
	input  wire logic            inputStartTrig,
	input  wire logic [NINT-1:0] internalTrig,
	// Generation side
	output logic                 sampleClkOut,
	output logic                 sampleUpdate,
	output logic                 startTrigOut,
	output logic                 genRunning,
	output logic                 genPaused,
	output logic      [NPFT-1:0] pftFiltered
);
	import output_trigger_pkg::*;

	localparam int SRCW = 3 + NINT + NPFT;

	genState_t          st_r;
	logic [31:0]        ctrl_r;
	logic [31:0]        custom_r;
	logic [31:0]        timing_r;
	logic [NPFT-1:0]    fltEn_r;
	logic [2*NPFT-1:0]  fltSet_r;
	logic [NPFT-1:0]    filt_r;
	logic [15:0]        fltCnt_r [NPFT];
	logic [15:0]        fltDiv_r [NPFT];
	logic [NPFT-1:0]    fltTick;
	logic [15:0]        fltN     [NPFT];
	logic               waitreq_r;
	logic [31:0]        rdata_r;
	logic [31:0]        rdMux;
	logic               swTrig_r;
	logic               trigPrev_r;
	logic               extPrev_r;
	logic [15:0]        dlyCnt_r;
	logic [15:0]        obCnt_r;
	logic               pend_r;
	logic [3:0]         updCnt_r;
	logic               sampleClk_r;
	logic               sampleUpd_r;
	logic               startOut_r;
	logic               running_r;
	logic               paused_r;
	logic [SRCW-1:0]    srcVec;
	logic               wrCommit;
	logic               reqTake;
	logic               goCmd;
	logic               stopCmd;
	logic               trigLvl;
	logic               trigEdge;
	logic               extLvl;
	logic               extEdge;
	logic               pauseLvl;
	logic               obTick;
	logic               sampleStart;
	logic               enterGen;
	genState_t          afterStart;

	// Pick one source bit; out-of-range codes read as low
	function automatic logic selSrc(input logic [3:0] sel, input logic [SRCW-1:0] vec);
		logic v;
		v = 1'b0;
		if (32'(sel) < SRCW)
			v = vec[sel];
		return v;
	endfunction

	// Matching samples needed for a setting
	function automatic logic [15:0] filtLen(input logic [1:0] set, input logic [15:0] customN);
		logic [15:0] n;
		n = customN;
		unique case (fltSet_t'(set))
			FLT_SHORT: n = 16'(`FLT_SHORT_N);
			FLT_MED:   n = 16'(`FLT_MED_N);
			FLT_HIGH:  n = 16'(`FLT_HIGH_N);
			FLT_CUSTOM: n = (customN == 16'h0000) ? 16'h0001 : customN;
		endcase
		return n;
	endfunction

	// Filter clock divisor in system clocks for a setting
	function automatic logic [15:0] filtDiv(input logic [1:0] set, input logic [15:0] customDiv);
		logic [15:0] d;
		d = customDiv;
		unique case (fltSet_t'(set))
			FLT_SHORT, FLT_MED: d = 16'(`FLT_FAST_DIV);
			FLT_HIGH:           d = 16'(`FLT_SLOW_DIV);
			FLT_CUSTOM:         d = (customDiv == 16'h0000) ? 16'h0001 : customDiv;
		endcase
		return d;
	endfunction

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Bus decode: one wait state, then the access completes
	assign reqTake  = (read || write) && waitreq_r;
	assign wrCommit = write && !waitreq_r;
	assign goCmd    = wrCommit && (address == `OFS_CMD) && writedata[`CMD_GO];
	assign stopCmd  = wrCommit && (address == `OFS_CMD) && writedata[`CMD_STOP];

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdMux = 32'h0000_0000;
		unique case (address)
			`OFS_CTRL:      rdMux = ctrl_r;
			`OFS_CMD:       rdMux = {29'h0000_0000, paused_r, running_r, st_r == ST_ARMED};
			`OFS_FLT_EN:    rdMux = 32'(fltEn_r);
			`OFS_FLT_SET:   rdMux = 32'(fltSet_r);
			`OFS_CUSTOM:    rdMux = custom_r;
			`OFS_TIMING:    rdMux = timing_r;
			`OFS_PFT_LEVEL: rdMux = 32'(filt_r);
			default:        rdMux = 32'h0000_0000;
		endcase
	end

	// Waitrequest drops one cycle after a request; read data is ready then
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			waitreq_r <= 1'b1;
			rdata_r   <= 32'h0000_0000;
		end
		else if (reqTake)
		begin
			waitreq_r <= 1'b0;
			rdata_r   <= rdMux;
		end
		else
			waitreq_r <= 1'b1;
	end

	// Configuration registers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctrl_r   <= `CTRL_RST;
			custom_r <= `CUSTOM_RST;
			timing_r <= `TIMING_RST;
			fltEn_r  <= NPFT'(`FLT_EN_RST);
			fltSet_r <= '0;
		end
		else if (wrCommit)
		begin
			unique case (address)
				`OFS_CTRL:    ctrl_r   <= writedata;
				`OFS_FLT_EN:  fltEn_r  <= writedata[NPFT-1:0];
				`OFS_FLT_SET: fltSet_r <= writedata[2*NPFT-1:0];
				`OFS_CUSTOM:  custom_r <= writedata;
				`OFS_TIMING:  timing_r <= writedata;
				default:      ;
			endcase
		end
	end

	// Software trigger pulse, one cycle
	always_ff @(posedge clk)
	begin
		if (!nrst)
			swTrig_r <= 1'b0;
		else
			swTrig_r <= wrCommit && (address == `OFS_CMD) && writedata[`CMD_SWTRIG];
	end

	// Filter clock ticks and required sample counts per terminal
	always_comb
	begin
		for (int i = 0; i < NPFT; i++)
		begin
			fltTick[i] = (fltDiv_r[i] == 16'h0000);
			fltN[i]    = filtLen(fltSet_r[2*i +: 2], custom_r[31:16]);
		end
	end

	// Debounce: a new level must be seen on N filter ticks in a row
	// Waiting for a tick costs up to one filter period of jitter
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			filt_r <= '0;
			for (int i = 0; i < NPFT; i++)
			begin
				fltCnt_r[i] <= 16'h0000;
				fltDiv_r[i] <= 16'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < NPFT; i++)
			begin
				if (!fltEn_r[i])
				begin
					filt_r[i]   <= pftIn[i];
					fltCnt_r[i] <= 16'h0000;
					fltDiv_r[i] <= 16'h0000;
				end
				else
				begin
					fltDiv_r[i] <= fltTick[i] ? filtDiv(fltSet_r[2*i +: 2], custom_r[15:0]) - 16'h0001
						: fltDiv_r[i] - 16'h0001;
					if (fltTick[i])
					begin
						if (pftIn[i] == filt_r[i])
							fltCnt_r[i] <= 16'h0000;
						else if (fltCnt_r[i] + 16'h0001 >= fltN[i])
						begin
							filt_r[i]   <= pftIn[i];
							fltCnt_r[i] <= 16'h0000;
						end
						else
							fltCnt_r[i] <= fltCnt_r[i] + 16'h0001;
					end
				end
			end
		end
	end

	// Source selection shared by start, pause and external clock
	assign srcVec   = {filt_r, internalTrig, inputStartTrig, inputRefTrig, swTrig_r};
	assign trigLvl  = selSrc(ctrl_r[`CTRL_START_SRC +: `SRC_W], srcVec);
	assign pauseLvl = ctrl_r[`CTRL_PAUSE_EN]
		&& (selSrc(ctrl_r[`CTRL_PAUSE_SRC +: `SRC_W], srcVec) == ctrl_r[`CTRL_PAUSE_HIGH]);
	assign extLvl   = selSrc(ctrl_r[`CTRL_EXT_SRC +: `SRC_W], srcVec);
	assign trigEdge = ctrl_r[`CTRL_EDGE_FALL] ? (trigPrev_r && !trigLvl) : (!trigPrev_r && trigLvl);
	assign extEdge  = extLvl && !extPrev_r;

	// Edge history
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			trigPrev_r <= 1'b0;
			extPrev_r  <= 1'b0;
		end
		else
		begin
			trigPrev_r <= trigLvl;
			extPrev_r  <= extLvl;
		end
	end

	// Delay applies only with the onboard clock
	assign afterStart = (ctrl_r[`CTRL_ONBOARD] && timing_r[31:16] != 16'h0000) ? ST_DELAY : ST_RUN;
	assign enterGen   = !stopCmd && ((st_r == ST_IDLE && goCmd && !ctrl_r[`CTRL_TRIG_EN])
		|| (st_r == ST_ARMED && trigEdge));

	// Generation sequencing
	always_ff @(posedge clk)
	begin
		if (!nrst)
			st_r <= ST_IDLE;
		else if (stopCmd)
			st_r <= ST_IDLE;
		else
		begin
			unique case (st_r)
				ST_IDLE:
					if (goCmd)
						st_r <= ctrl_r[`CTRL_TRIG_EN] ? ST_ARMED : afterStart;
				ST_ARMED:
					if (trigEdge)
						st_r <= afterStart;
				ST_DELAY:
					if (dlyCnt_r == 16'h0000)
						st_r <= ST_RUN;
				ST_RUN:
					st_r <= ST_RUN;
			endcase
		end
	end

	// Start-to-first-sample delay counter
	always_ff @(posedge clk)
	begin
		if (!nrst)
			dlyCnt_r <= 16'h0000;
		else if (enterGen)
			dlyCnt_r <= timing_r[31:16] - 16'h0001;
		else if (st_r == ST_DELAY && dlyCnt_r != 16'h0000)
			dlyCnt_r <= dlyCnt_r - 16'h0001;
	end

	// Routed start trigger: one-cycle high pulse
	always_ff @(posedge clk)
	begin
		if (!nrst)
			startOut_r <= 1'b0;
		else
			startOut_r <= st_r == ST_ARMED && trigEdge && !stopCmd;
	end

	// Onboard sample clock divider, first tick on entering run
	assign obTick = ctrl_r[`CTRL_ONBOARD] && st_r == ST_RUN && obCnt_r == 16'h0000;

	always_ff @(posedge clk)
	begin
		if (!nrst || st_r != ST_RUN)
			obCnt_r <= 16'h0000;
		else if (obTick)
			obCnt_r <= (timing_r[15:0] == 16'h0000) ? 16'h0000 : timing_r[15:0] - 16'h0001;
		else
			obCnt_r <= obCnt_r - 16'h0001;
	end

	// Onboard ticks held off by pause are kept so the clock resumes at once
	always_ff @(posedge clk)
	begin
		if (!nrst || st_r != ST_RUN)
			pend_r <= 1'b0;
		else if (sampleStart)
			pend_r <= 1'b0;
		else if (obTick && pauseLvl)
			pend_r <= 1'b1;
	end

	// Pause is checked only when a sample begins, never mid-sample
	// External edges seen while paused are dropped on purpose
	assign sampleStart = st_r == ST_RUN && !pauseLvl && !sampleClk_r
		&& (ctrl_r[`CTRL_ONBOARD] ? (obTick || pend_r) : extEdge);

	// Sample clock out, active high for a fixed update time
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			sampleClk_r <= 1'b0;
			updCnt_r    <= 4'h0;
		end
		else if (sampleStart)
		begin
			sampleClk_r <= 1'b1;
			updCnt_r    <= 4'(`SAMPLE_HIGH - 1);
		end
		else if (updCnt_r != 4'h0)
			updCnt_r <= updCnt_r - 4'h1;
		else
			sampleClk_r <= 1'b0;
	end

	// Status flags
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			sampleUpd_r <= 1'b0;
			running_r   <= 1'b0;
			paused_r    <= 1'b0;
		end
		else
		begin
			sampleUpd_r <= sampleStart;
			running_r   <= st_r == ST_RUN;
			paused_r    <= st_r == ST_RUN && pauseLvl;
		end
	end

	assign readdata     = rdata_r;
	assign waitrequest  = waitreq_r;
	assign sampleClkOut = sampleClk_r;
	assign sampleUpdate = sampleUpd_r;
	assign startTrigOut = startOut_r;
	assign genRunning   = running_r;
	assign genPaused    = paused_r;
	assign pftFiltered  = filt_r;

	// Checks
	sequence s_sampleBegins;
		$rose(sampleClk_r);
	endsequence
	sequence s_sampleHeld;
		sampleClk_r [*2] ##1 !sampleClk_r;
	endsequence

	property p_startEdge;
		st_r == ST_ARMED && trigEdge && !stopCmd |=> startOut_r && st_r != ST_ARMED;
	endproperty
	a_startEdge: assert property (p_startEdge) else $error("start edge not taken");

	property p_startPulse;
		startOut_r |=> !startOut_r;
	endproperty
	a_startPulse: assert property (p_startPulse) else $error("start pulse too long");

	property p_pauseBlocks;
		pauseLvl |=> !sampleUpd_r;
	endproperty
	a_pauseBlocks: assert property (p_pauseBlocks) else $error("sample during pause");

	property p_sampleWhole;
		s_sampleBegins |-> s_sampleHeld;
	endproperty
	a_sampleWhole: assert property (p_sampleWhole) else $error("sample update cut short");

	property p_onboardResume;
		ctrl_r[`CTRL_ONBOARD] && st_r == ST_RUN && pend_r && !pauseLvl && !sampleClk_r |=> sampleUpd_r;
	endproperty
	a_onboardResume: assert property (p_onboardResume) else $error("onboard resume late");

	property p_extNeedsEdge;
		!ctrl_r[`CTRL_ONBOARD] && !extEdge |=> !sampleUpd_r;
	endproperty
	a_extNeedsEdge: assert property (p_extNeedsEdge) else $error("sample without clock edge");

	property p_filterPass;
		fltEn_r[0] && fltTick[0] && pftIn[0] != filt_r[0] && fltCnt_r[0] + 16'h0001 >= fltN[0]
			|=> filt_r[0] == $past(pftIn[0]);
	endproperty
	a_filterPass: assert property (p_filterPass) else $error("filtered level not passed");

	property p_filterRestart;
		fltEn_r[0] && fltTick[0] && pftIn[0] == filt_r[0] |=> fltCnt_r[0] == 16'h0000 && $stable(filt_r[0]);
	endproperty
	a_filterRestart: assert property (p_filterRestart) else $error("filter count not restarted");

	property p_filtOffAtReset;
		$rose(nrst) |-> fltEn_r == '0 ##1 fltEn_r == '0 || $past(wrCommit);
	endproperty
	a_filtOffAtReset: assert property (p_filtOffAtReset) else $error("filter enabled at reset");

	property p_softStart;
		st_r == ST_IDLE && goCmd && !stopCmd && !ctrl_r[`CTRL_TRIG_EN] |=> st_r == ST_DELAY || st_r == ST_RUN;
	endproperty
	a_softStart: assert property (p_softStart) else $error("software start ignored");

endmodule
`default_nettype wire

// file: trig_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module trig_source_model #(
	parameter int NPFT = 4,
	parameter int NINT = 2
) (
	// Clock
	input  wire logic            clk,
	// Levels commanded by the bench
	input  wire logic [7:0]      lineLvl,
	input  wire logic            extClkEn,
	// Lines toward the block
	output logic      [NPFT-1:0] pftIn,
	output logic                 inputRefTrig,
	output logic                 inputStartTrig,
	output logic      [NINT-1:0] internalTrig
);
	logic [2:0] phase;

	// External sample clock, 8-cycle period; stands still low when disabled
	always_ff @(posedge clk)
	begin
		if (extClkEn)
			phase <= phase + 3'h1;
		else
			phase <= 3'h0;
	end

	// Lines hold commanded levels so the only edges are the ones a scenario asks for
	assign inputRefTrig   = lineLvl[0];
	assign inputStartTrig = lineLvl[1];
	assign internalTrig   = {lineLvl[3], extClkEn ? phase[2] : lineLvl[2]};
	assign pftIn          = lineLvl[7:4];
endmodule
`default_nettype wire

// file: output_trigger_and_pin_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module output_trigger_and_pin_filter_tb;
	logic        clk;
	logic        nrst;
	logic [4:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [7:0]  lineLvl;
	logic        extClkEn;
	logic [3:0]  pftIn;
	logic        inputRefTrig;
	logic        inputStartTrig;
	logic [1:0]  internalTrig;
	logic        sampleClkOut;
	logic        sampleUpdate;
	logic        startTrigOut;
	logic        genRunning;
	logic        genPaused;
	logic [3:0]  pftFiltered;
	int          errors;
	int          compares;
	int          cycles;

	output_trigger_and_pin_filter output_trigger_and_pin_filter_inst (.clk(clk), .nrst(nrst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.pftIn(pftIn), .inputRefTrig(inputRefTrig), .inputStartTrig(inputStartTrig), .internalTrig(internalTrig),
		.sampleClkOut(sampleClkOut), .sampleUpdate(sampleUpdate), .startTrigOut(startTrigOut),
		.genRunning(genRunning), .genPaused(genPaused), .pftFiltered(pftFiltered));
	trig_source_model trig_source_model_inst (.clk(clk), .lineLvl(lineLvl), .extClkEn(extClkEn), .pftIn(pftIn),
		.inputRefTrig(inputRefTrig), .inputStartTrig(inputStartTrig), .internalTrig(internalTrig));

	task automatic summarize();
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Avalon master: hold the request until waitrequest is seen low at an edge
	task automatic busWrite(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic busRead(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask

	task automatic countUpd(input int n, output int c);
		c = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (sampleUpdate === 1'b1)
				c++;
		end
	endtask

	task automatic regsTest();
		logic [31:0] d;
		busRead(5'h00, d);
		`CHK("ctrlRst", 32'h0001_0000, d)
		busRead(5'h08, d);
		`CHK("fltEnRst", 32'h0000_0000, d)
		busRead(5'h10, d);
		`CHK("customRst", 32'h0001_0001, d)
		busRead(5'h1C, d);
		`CHK("unmapped", 32'h0000_0000, d)
	endtask

	task automatic filterTest();
		logic [31:0] d;
		busWrite(5'h0C, 32'h0000_0000);
		lineLvl[5] <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("unfiltered", 1'b1, pftFiltered[1])
		busWrite(5'h08, 32'h0000_0001);
		lineLvl[4] <= 1'b1;
		repeat (2) @(posedge clk);
		lineLvl[4] <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("glitch", 1'b0, pftFiltered[0])
		lineLvl[4] <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("early", 1'b0, pftFiltered[0])
		repeat (6) @(posedge clk);
		`CHK("rise", 1'b1, pftFiltered[0])
		lineLvl[4] <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("fall", 1'b0, pftFiltered[0])
		// Medium preset needs 128 matching samples
		busWrite(5'h0C, 32'h0000_0001);
		lineLvl[4] <= 1'b1;
		repeat (100) @(posedge clk);
		`CHK("medEarly", 1'b0, pftFiltered[0])
		repeat (40) @(posedge clk);
		`CHK("medPass", 1'b1, pftFiltered[0])
		busRead(5'h18, d);
		`CHK("levels", 4'h3, d[3:0])
		// Custom: divisor 4, two samples
		busWrite(5'h10, 32'h0002_0004);
		busWrite(5'h0C, 32'h0000_0003);
		lineLvl[4] <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("custEarly", 1'b1, pftFiltered[0])
		repeat (12) @(posedge clk);
		`CHK("custPass", 1'b0, pftFiltered[0])
	endtask

	// Arm on source c; a line source shows the wrong edge first, then the chosen one, source 0 uses the software trigger
	task automatic startTest(input logic [3:0] c, input logic fall);
		logic [31:0] d;
		int          k;
		busWrite(5'h04, 32'h0000_0004);
		if (c != 4'h0)
			lineLvl[c - 4'h1] <= !fall;
		repeat (4) @(posedge clk);
		busWrite(5'h00, 32'h0001_0001 | (32'(c) << 4) | (32'(fall) << 1));
		busWrite(5'h04, 32'h0000_0001);
		busRead(5'h04, d);
		`CHK("armed", 1'b1, d[0])
		if (c != 4'h0)
		begin
			lineLvl[c - 4'h1] <= fall;
			repeat (5) @(posedge clk);
			`CHK("wrongEdge", 1'b0, genRunning)
			lineLvl[c - 4'h1] <= !fall;
		end
		else
			busWrite(5'h04, 32'h0000_0002);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (startTrigOut !== 1'b1 && k < 20);
		`CHK("trigPulse", 1'b1, startTrigOut)
		@(posedge clk);
		`CHK("pulseWidth", 1'b0, startTrigOut)
		repeat (3) @(posedge clk);
		`CHK("running", 1'b1, genRunning)
	endtask

	task automatic pauseOnboard();
		int c;
		int k;
		busWrite(5'h04, 32'h0000_0004);
		busWrite(5'h14, 32'h0008_0004);
		busWrite(5'h00, 32'h0001_4300);
		busWrite(5'h04, 32'h0000_0001);
		// Eight delay cycles before the first sample, so nine quiet edges
		countUpd(9, c);
		`CHK("delayed", 1'b1, c == 0)
		countUpd(20, c);
		`CHK("obRun", 1'b1, c >= 4)
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (sampleUpdate !== 1'b1 && k < 10);
		lineLvl[3] <= 1'b1;
		@(posedge clk);
		`CHK("holdHigh", 1'b1, sampleClkOut)
		@(posedge clk);
		`CHK("lowAfter", 1'b0, sampleClkOut)
		// Unpause one cycle after a held-off tick, well before the next tick
		countUpd(21, c);
		`CHK("paused", 1'b1, c == 0)
		`CHK("pausedFlag", 1'b1, genPaused)
		lineLvl[3] <= 1'b0;
		countUpd(2, c);
		`CHK("resumeNow", 1'b1, c == 1)
		busWrite(5'h00, 32'h0001_4100);
		repeat (8) @(posedge clk);
		countUpd(20, c);
		`CHK("pauseLow", 1'b1, c == 0)
	endtask

	task automatic pauseExternal();
		int c;
		busWrite(5'h04, 32'h0000_0004);
		busWrite(5'h00, 32'h0030_4300);
		extClkEn <= 1'b1;
		busWrite(5'h04, 32'h0000_0001);
		countUpd(40, c);
		`CHK("extRun", 1'b1, c >= 4)
		lineLvl[3] <= 1'b1;
		repeat (10) @(posedge clk);
		countUpd(40, c);
		`CHK("extPaused", 1'b1, c == 0)
		extClkEn <= 1'b0;
		repeat (4) @(posedge clk);
		lineLvl[3] <= 1'b0;
		countUpd(16, c);
		`CHK("noEdgeNoRun", 1'b1, c == 0)
		extClkEn <= 1'b1;
		countUpd(12, c);
		`CHK("edgeResumes", 1'b1, c >= 1)
		busWrite(5'h04, 32'h0000_0004);
	endtask

	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard: far beyond the few hundred cycles the scenarios need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			summarize();
		end
	end

	// Main sequence
	initial
	begin
		errors = 0;
		compares = 0;
		cycles = 0;
		nrst = 1'b0;
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		lineLvl = 8'h00;
		extClkEn = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		regsTest();
		filterTest();
		startTest(4'h0, 1'b0);
		startTest(4'h1, 1'b1);
		startTest(4'h2, 1'b0);
		startTest(4'h3, 1'b1);
		startTest(4'h6, 1'b0);
		pauseOnboard();
		pauseExternal();
		summarize();
	end
endmodule
`default_nettype wire
